// >>> acc_clk_div.sv
`timescale 1ns/1ps
module acc_clk_div
	import acc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       run,
	input  wire logic [3:0] div_sel,
	output logic            half_tick,
	output logic            tick
);

	logic [7:0] cnt;
	logic       phase;

	// Counter cleared to zero on reaching half the selected divide ratio
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt       <= 8'h00;
			phase     <= 1'b0;
			half_tick <= 1'b0;
			tick      <= 1'b0;
		end else if (!run) begin
			cnt       <= 8'h00;
			phase     <= 1'b0;
			half_tick <= 1'b0;
			tick      <= 1'b0;
		end else if (cnt + 8'h01 >= DIV_HALF[div_sel]) begin
			cnt       <= 8'h00;
			phase     <= ~phase;
			half_tick <= 1'b1;
			tick      <= phase;
		end else begin
			cnt       <= cnt + 8'h01;
			half_tick <= 1'b0;
			tick      <= 1'b0;
		end
	end

endmodule : acc_clk_div

// >>> acc_ctrl.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// Function
// - Standby without run flag stops after ongoing conversion; with it keeps running
// - Single-ended mode uses positive input, unsigned result
// - Differential mode uses both inputs, signed result
// - Left justify places result left aligned, only with accumulation code 0
// - Resolution code 0 gives 12 bits, code 1 gives 10 bits
// - Conversion lasts 13.5 or 11.5 converter clocks
// - Continuous mode repeats after the first software start
// - Converter works only while enable is set
// - Accumulate two to the n samples, code 0 none
// - Divider select gives ratios 2 to 256
// - Start-up delay 0 to 256 cycles after enabling
// - Start-up delay also after deep sleep wake
// - Gap of 0 to 15 cycles between consecutive samples
// - Window compare uses 16-bit result and thresholds
// - Window mode selects never, below, above, inside or outside
// - Start command queues, reads busy, clears at completion
// - Result ready set on completion, cleared by write 1 or result read
// - Window flag set at conversion end only on a match
// - Sampling lasts two cycles plus the extension field
module acc_ctrl
	import acc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        standby_req,
	input  wire logic        deep_wake,
	input  wire logic [11:0] fe_data,
	output logic             fe_sample,
	output logic             fe_convert,
	output logic             fe_two_input_mode,
	output logic [1:0]       fe_res_sel
);

	logic [7:0]  control_main;
	logic [7:0]  accumulation_control;
	logic [7:0]  clock_prescale_control;
	logic [7:0]  delay_control;
	logic [7:0]  window_control;
	logic [7:0]  sample_length_ext;
	logic [15:0] window_low_threshold;
	logic [15:0] window_high_threshold;
	logic [15:0] conversion_output_reg;
	logic        result_ready_flag;
	logic        window_match_flag;
	logic        cmd_busy;
	logic        start_queued;
	logic        need_init;
	logic        enable_q;
	logic        stby_m;
	logic        stby_s;
	logic        stby_q;
	logic        wake_m;
	logic        wake_s;
	logic        wake_q;
	logic        aw_held;
	logic        w_held;
	logic [5:0]  aw_idx;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	acc_state_t  state;
	logic [8:0]  cnt;
	logic [7:0]  nsamp;
	logic [19:0] acc;
	logic        half_tick;
	logic        tick;

	wire       enable   = control_main[B_ENABLE];
	wire       continuous_conversion  = control_main[B_CONTINUOUS_CONVERSION];
	wire       two_input_mode     = control_main[B_TWO_INPUT_MODE];
	wire [1:0] res_sel  = control_main[B_RES_HI:B_RES_LO];
	wire       res10    = (res_sel == RES_10BIT);
	wire [2:0] accum_n  = accumulation_control[2:0];
	wire [8:0] init_len = INIT_LEN[delay_control[7:5]];
	wire [3:0] gap      = delay_control[3:0];
	wire       run_ok   = enable & (~stby_s | control_main[B_STBY_RUN]);
	wire       wr_go    = aw_held & w_held & ~s_axi_bvalid;
	wire       ar_hs    = s_axi_arvalid & s_axi_arready;
	wire [5:0] ar_idx   = s_axi_araddr[7:2];
	wire       wr_cmd   = wr_go & (aw_idx == IDX_COMMAND) & wstrb_q[0];
	wire       wr_flag  = wr_go & (aw_idx == IDX_FLAGS) & wstrb_q[0];
	wire       start_wr = wr_cmd & wdata_q[B_START];
	wire       stop_wr  = wr_cmd & wdata_q[B_STOP];
	wire       res_rd   = ar_hs & (ar_idx == IDX_RESULT);
	wire [7:0] last_n   = (8'h01 << accum_n) - 8'h01;

	logic [8:0]  len;
	logic        step;
	logic        phase_end;
	logic        conv_done;
	logic        continue_run;
	logic [19:0] samp_ext;
	logic [19:0] acc_sum;
	logic [15:0] final_val;
	logic        win_hit;
	logic [7:0]  rd_byte;
	logic [15:0] rd_word;
	logic        rd_map;
	logic        wr_map;

	acc_clk_div u_div (
		.core_clk  (core_clk),
		.rstn      (rstn),
		.run       (enable),
		.div_sel   (clock_prescale_control[3:0]),
		.half_tick (half_tick),
		.tick      (tick)
	);

	// Pin synchronisers and edge history
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			stby_m   <= 1'b0;
			stby_s   <= 1'b0;
			stby_q   <= 1'b0;
			wake_m   <= 1'b0;
			wake_s   <= 1'b0;
			wake_q   <= 1'b0;
			enable_q <= 1'b0;
		end else begin
			stby_m   <= standby_req;
			stby_s   <= stby_m;
			stby_q   <= stby_s;
			wake_m   <= deep_wake;
			wake_s   <= wake_m;
			wake_q   <= wake_s;
			enable_q <= enable;
		end
	end

	// Phase length and step
	always_comb begin
		len  = 9'h000;
		step = tick;
		unique case (state)
			ST_INIT: len = init_len;
			ST_SAMP: len = SAMPLE_BASE + {1'b0, sample_length_ext};
			ST_CONV: begin
				len  = res10 ? CONV10_HALF : CONV12_HALF;
				step = half_tick;
			end
			ST_GAP:  len = {5'h00, gap};
			default: len = 9'h000;
		endcase
		phase_end = step & (cnt + 9'h001 >= len);
	end

	// Sample shaping, accumulation and window test
	always_comb begin
		if (res10)
			samp_ext = {{10{two_input_mode & fe_data[11]}}, fe_data[11:2]};
		else
			samp_ext = {{8{two_input_mode & fe_data[11]}}, fe_data};
		acc_sum = acc + samp_ext;
		if (accum_n != 3'h0)
			final_val = acc_sum[15:0];
		else if (control_main[B_LEFT])
			final_val = res10 ? {samp_ext[9:0], 6'h00}
				: {samp_ext[11:0], 4'h0};
		else
			final_val = samp_ext[15:0];
		conv_done = enable & ~stop_wr & (state == ST_CONV) & phase_end
			& (nsamp == last_n);
		continue_run = continuous_conversion & run_ok;
		win_hit = win_eval(final_val);
	end

	function automatic logic win_eval(input logic [15:0] v);
		logic lt;
		logic gt;
		lt = two_input_mode ? ($signed(v) < $signed(window_low_threshold))
			: (v < window_low_threshold);
		gt = two_input_mode ? ($signed(v) > $signed(window_high_threshold))
			: (v > window_high_threshold);
		unique case (window_control[2:0])
			WIN_BELOW:   win_eval = lt;
			WIN_ABOVE:   win_eval = gt;
			WIN_INSIDE:  win_eval = ~lt & ~gt;
			WIN_OUTSIDE: win_eval = lt | gt;
			default:     win_eval = 1'b0;
		endcase
	endfunction : win_eval

	// Conversion sequencer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			cnt   <= 9'h000;
			nsamp <= 8'h00;
			acc   <= 20'h00000;
		end else if (!enable || stop_wr) begin
			state <= ST_IDLE;
			cnt   <= 9'h000;
			nsamp <= 8'h00;
			acc   <= 20'h00000;
		end else begin
			unique case (state)
				ST_IDLE: if (cmd_busy && run_ok) begin
					cnt   <= 9'h000;
					nsamp <= 8'h00;
					acc   <= 20'h00000;
					state <= (need_init && init_len != 9'h000)
						? ST_INIT : ST_SAMP;
				end
				ST_INIT, ST_GAP: if (phase_end) begin
					cnt   <= 9'h000;
					state <= ST_SAMP;
				end else if (step) begin
					cnt <= cnt + 9'h001;
				end
				ST_SAMP: if (phase_end) begin
					cnt   <= 9'h000;
					state <= ST_CONV;
				end else if (step) begin
					cnt <= cnt + 9'h001;
				end
				ST_CONV: if (phase_end) begin
					cnt <= 9'h000;
					if (nsamp == last_n) begin
						acc   <= 20'h00000;
						nsamp <= 8'h00;
						if (continue_run)
							state <= (gap != 4'h0) ? ST_GAP : ST_SAMP;
						else
							state <= ST_IDLE;
					end else begin
						acc   <= acc_sum;
						nsamp <= nsamp + 8'h01;
						state <= (gap != 4'h0) ? ST_GAP : ST_SAMP;
					end
				end else if (step) begin
					cnt <= cnt + 9'h001;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Start command and queued start
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_busy     <= 1'b0;
			start_queued <= 1'b0;
		end else if (!enable || stop_wr) begin
			cmd_busy     <= 1'b0;
			start_queued <= 1'b0;
		end else if (conv_done) begin
			cmd_busy     <= start_wr | start_queued | continue_run;
			start_queued <= 1'b0;
		end else if (start_wr) begin
			cmd_busy     <= 1'b1;
			start_queued <= (state != ST_IDLE);
		end
	end

	// Start-up delay request
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			need_init <= 1'b0;
		else if ((enable && !enable_q) || (wake_s && !wake_q)
			|| (stby_q && !stby_s && !control_main[B_STBY_RUN]))
			need_init <= 1'b1;
		else if (state != ST_IDLE && state != ST_INIT)
			need_init <= 1'b0;
	end

	// Result and flags; setting wins over clearing
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			conversion_output_reg <= RESET_WORD;
			result_ready_flag     <= 1'b0;
			window_match_flag     <= 1'b0;
		end else begin
			if (conv_done)
				conversion_output_reg <= final_val;
			if (conv_done)
				result_ready_flag <= 1'b1;
			else if (res_rd || (wr_flag && wdata_q[B_RRDY]))
				result_ready_flag <= 1'b0;
			if (conv_done && win_hit)
				window_match_flag <= 1'b1;
			else if (res_rd || (wr_flag && wdata_q[B_WMATCH]))
				window_match_flag <= 1'b0;
		end
	end

	// Software-written registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			control_main           <= RESET_BYTE;
			accumulation_control   <= RESET_BYTE;
			clock_prescale_control <= RESET_BYTE;
			delay_control          <= RESET_BYTE;
			window_control         <= RESET_BYTE;
			sample_length_ext      <= RESET_BYTE;
			window_low_threshold   <= RESET_WORD;
			window_high_threshold  <= RESET_WORD;
		end else if (wr_go) begin
			if (wstrb_q[0]) begin
				unique case (aw_idx)
					IDX_CTRL_MAIN:
						control_main <= wdata_q[7:0] & MASK_CTRL_MAIN;
					IDX_ACCUM:
						accumulation_control <= wdata_q[7:0] & MASK_ACCUM;
					IDX_PRESCALE:
						clock_prescale_control <= wdata_q[7:0] & MASK_PRESCALE;
					IDX_DELAY:
						delay_control <= wdata_q[7:0] & MASK_DELAY;
					IDX_WINDOW:
						window_control <= wdata_q[7:0] & MASK_WINDOW;
					IDX_SAMPLE_LEN: sample_length_ext <= wdata_q[7:0];
					IDX_WIN_LOW:  window_low_threshold[7:0] <= wdata_q[7:0];
					IDX_WIN_HIGH: window_high_threshold[7:0] <= wdata_q[7:0];
					default: ;
				endcase
			end
			if (wstrb_q[1] && aw_idx == IDX_WIN_LOW)
				window_low_threshold[15:8] <= wdata_q[15:8];
			if (wstrb_q[1] && aw_idx == IDX_WIN_HIGH)
				window_high_threshold[15:8] <= wdata_q[15:8];
		end
	end

	// Address decode
	always_comb begin
		rd_byte = 8'h00;
		rd_word = 16'h0000;
		rd_map  = 1'b1;
		unique case (ar_idx)
			IDX_CTRL_MAIN:  rd_byte = control_main;
			IDX_ACCUM:      rd_byte = accumulation_control;
			IDX_PRESCALE:   rd_byte = clock_prescale_control;
			IDX_DELAY:      rd_byte = delay_control;
			IDX_WINDOW:     rd_byte = window_control;
			IDX_SAMPLE_LEN: rd_byte = sample_length_ext;
			IDX_COMMAND:    rd_byte = {7'h00, cmd_busy};
			IDX_FLAGS:
				rd_byte = {6'h00, window_match_flag, result_ready_flag};
			IDX_RESULT:     rd_word = conversion_output_reg;
			IDX_WIN_LOW:    rd_word = window_low_threshold;
			IDX_WIN_HIGH:   rd_word = window_high_threshold;
			default:        rd_map = 1'b0;
		endcase
		unique case (aw_idx)
			IDX_CTRL_MAIN, IDX_ACCUM, IDX_PRESCALE, IDX_DELAY, IDX_WINDOW,
			IDX_SAMPLE_LEN, IDX_COMMAND, IDX_FLAGS, IDX_RESULT, IDX_WIN_LOW,
			IDX_WIN_HIGH: wr_map = 1'b1;
			default:      wr_map = 1'b0;
		endcase
	end

	// Write channels
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_idx        <= 6'h00;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held       <= 1'b1;
				aw_idx        <= s_axi_awaddr[7:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held       <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read channel
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {16'h0000, rd_word | {8'h00, rd_byte}};
			s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Front-end controls
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fe_sample  <= 1'b0;
			fe_convert <= 1'b0;
			fe_two_input_mode    <= 1'b0;
			fe_res_sel <= 2'h0;
		end else begin
			fe_sample  <= state[2];
			fe_convert <= state[3];
			fe_two_input_mode    <= two_input_mode;
			fe_res_sel <= res_sel;
		end
	end

endmodule : acc_ctrl

// >>> acc_ctrl_chk.sv
`timescale 1ns/1ps
module acc_ctrl_chk
	import acc_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        fe_sample,
	input wire logic        fe_convert,
	input wire logic        fe_two_input_mode,
	input wire logic [1:0]  fe_res_sel
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence conv_run;
		fe_convert [*8];
	endsequence
	sequence samp_seen;
		fe_sample || $past(fe_sample);
	endsequence

	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two edges after handshake");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during answer");
	conv_len_a: assert property ($rose(fe_convert) |-> conv_run)
		else $error("conversion phase too short");
	samp_first_a: assert property ($rose(fe_convert) |-> samp_seen)
		else $error("conversion without sampling");
	res_follow_a: assert property (!$stable(fe_res_sel)
		|-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("resolution changed without write");
	two_input_mode_follow_a: assert property (!$stable(fe_two_input_mode)
		|-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("mode changed without write");
endmodule : acc_ctrl_chk

bind acc_ctrl acc_ctrl_chk chk_i (.core_clk, .rstn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .fe_sample, .fe_convert, .fe_two_input_mode,
	.fe_res_sel);

// >>> acc_fe_model.sv
`timescale 1ns/1ps
module acc_fe_model
	import acc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        fe_convert,
	input  wire logic [11:0] code,
	output logic [11:0]      fe_data
);
	logic [11:0] churn = 12'hA5A;

	// Pattern churns outside conversion
	always @(posedge core_clk) begin
		churn <= ~churn ^ 12'h001;
	end

	// Code held through conversion, two's complement in differential
	assign fe_data = fe_convert ? code : churn;
endmodule : acc_fe_model

// >>> acc_pkg.sv
package acc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL_MAIN  = 6'h00;
	localparam logic [5:0] IDX_ACCUM      = 6'h01;
	localparam logic [5:0] IDX_PRESCALE   = 6'h02;
	localparam logic [5:0] IDX_DELAY      = 6'h03;
	localparam logic [5:0] IDX_WINDOW     = 6'h04;
	localparam logic [5:0] IDX_SAMPLE_LEN = 6'h05;
	localparam logic [5:0] IDX_COMMAND    = 6'h0A;
	localparam logic [5:0] IDX_FLAGS      = 6'h0D;
	localparam logic [5:0] IDX_RESULT     = 6'h10;
	localparam logic [5:0] IDX_WIN_LOW    = 6'h12;
	localparam logic [5:0] IDX_WIN_HIGH   = 6'h14;

	// Writable bits per register
	localparam logic [7:0] MASK_CTRL_MAIN = 8'hBF;
	localparam logic [7:0] MASK_ACCUM     = 8'h07;
	localparam logic [7:0] MASK_PRESCALE  = 8'h0F;
	localparam logic [7:0] MASK_DELAY     = 8'hEF;
	localparam logic [7:0] MASK_WINDOW    = 8'h07;
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [15:0] RESET_WORD    = 16'h0000;

	// Field positions
	localparam int B_ENABLE   = 0;
	localparam int B_CONTINUOUS_CONVERSION  = 1;
	localparam int B_RES_LO   = 2;
	localparam int B_RES_HI   = 3;
	localparam int B_LEFT     = 4;
	localparam int B_TWO_INPUT_MODE     = 5;
	localparam int B_STBY_RUN = 7;
	localparam int B_START    = 0;
	localparam int B_STOP     = 1;
	localparam int B_RRDY     = 0;
	localparam int B_WMATCH   = 1;

	localparam logic [1:0] RES_10BIT = 2'h1;

	// Timing in converter clock cycles (conversion in half cycles)
	localparam logic [8:0] SAMPLE_BASE  = 9'h002;
	localparam logic [8:0] CONV12_HALF  = 9'h01B;
	localparam logic [8:0] CONV10_HALF  = 9'h017;

	// Half of each divide ratio, in peripheral clock cycles
	localparam logic [7:0] DIV_HALF [16] = '{8'h01, 8'h02, 8'h04, 8'h06,
		8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40,
		8'h80, 8'h80, 8'h80};
	localparam logic [8:0] INIT_LEN [8] = '{9'h000, 9'h010, 9'h020,
		9'h040, 9'h080, 9'h100, 9'h100, 9'h100};

	localparam logic [2:0] WIN_BELOW   = 3'h1;
	localparam logic [2:0] WIN_ABOVE   = 3'h2;
	localparam logic [2:0] WIN_INSIDE  = 3'h3;
	localparam logic [2:0] WIN_OUTSIDE = 3'h4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_INIT = 5'h02,
		ST_SAMP = 5'h04,
		ST_CONV = 5'h08,
		ST_GAP  = 5'h10
	} acc_state_t;

endpackage : acc_pkg

// >>> adc_control_config_test.sv
`timescale 1ns/1ps
module adc_control_config_test
	import acc_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h3;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        standby_req = 1'b0;
	logic        deep_wake = 1'b0;
	logic [11:0] code = 12'h000;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, fe_sample, fe_convert, fe_two_input_mode;
	logic [1:0]  s_axi_bresp, s_axi_rresp, fe_res_sel, last_b, last_r;
	logic [31:0] s_axi_rdata, rdat, lfsr = 32'hD53F;
	logic [11:0] fe_data;
	int          err_total = 0, samples_checked = 0, cyc = 0;
	int          run_len = 0, last_len = 0, rises = 0;

	acc_ctrl dut (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby_req,
		.deep_wake, .fe_data, .fe_sample, .fe_convert, .fe_two_input_mode, .fe_res_sel);
	acc_fe_model fe (.core_clk, .fe_convert, .code, .fe_data);

	always #50 core_clk = ~core_clk;

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt

	function automatic logic [7:0] msk(input int i);
		case (i)
			0: return MASK_CTRL_MAIN;
			1: return MASK_ACCUM;
			2: return MASK_PRESCALE;
			3: return MASK_DELAY;
			4: return MASK_WINDOW;
			default: return 8'hFF;
		endcase
	endfunction : msk

	function automatic logic [15:0] exp_res(input logic [11:0] c,
		input logic r10, input logic lj, input int n);
		logic [19:0] v;
		v = r10 ? {10'h0, c[11:2]} : {8'h0, c};
		v = v << n;
		if (n == 0 && lj) v = r10 ? v << 6 : v << 4;
		return v[15:0];
	endfunction : exp_res

	function automatic logic wmatch(input logic [15:0] r, lo, hi,
		input logic [2:0] m);
		case (m)
			3'h1: return r < lo;
			3'h2: return r > hi;
			3'h3: return r >= lo && r <= hi;
			3'h4: return r < lo || r > hi;
			default: return 1'b0;
		endcase
	endfunction : wmatch

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		last_b = s_axi_bresp;
	endtask : wr

	task automatic rd(input logic [5:0] idx);
		@(posedge core_clk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rdat = s_axi_rdata;
		last_r = s_axi_rresp;
	endtask : rd

	task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
		rd(idx);
		chk(rdat, exp);
	endtask : rdc

	task automatic wait_done;
		do rd(IDX_FLAGS); while (rdat[0] !== 1'b1);
	endtask : wait_done

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (fe_convert) begin
			run_len <= run_len + 1;
			if (run_len == 0) rises <= rises + 1;
		end else if (run_len != 0) begin
			last_len <= run_len;
			run_len <= 0;
		end
		if (cyc == 60000) begin
			err_total++;
			tally_and_finish;
		end
	end

	initial begin
		logic [15:0] lo, hi, ex;
		logic        wm;
		int          n, h, r0;
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++) rdc(6'(i), 32'h0);
		rdc(IDX_FLAGS, 32'h0);
		rdc(IDX_WIN_HIGH, 32'h0);
		for (int i = 0; i < 6; i++) begin
			lfsr = nxt(lfsr);
			wr(6'(i), lfsr[15:0]);
			rdc(6'(i), {24'h0, lfsr[7:0] & msk(i)});
			wr(6'(i), 16'h0);
		end
		wr(6'h3F, 16'h00FF);
		chk(32'(last_b), 32'(RESP_SLVERR));
		rd(6'h3F);
		chk({last_r, rdat[29:0]}, {RESP_SLVERR, 30'h0});
		for (int k = 0; k < 4; k++) begin
			lfsr = nxt(lfsr);
			code <= lfsr[11:0];
			n = (k == 3) ? 2 : 0;
			h = (k == 3) ? 6 : (1 << k);
			lo = {1'b0, lfsr[26:12]};
			hi = lo + 16'h4000;
			wr(IDX_ACCUM, 16'(n));
			wr(IDX_PRESCALE, 16'(k));
			wr(IDX_DELAY, {8'h0, 3'h1, 1'b0, lfsr[31:28]});
			wr(IDX_SAMPLE_LEN, 16'(k));
			wr(IDX_WIN_LOW, lo);
			wr(IDX_WIN_HIGH, hi);
			wr(IDX_WINDOW, 16'(k + 1));
			wr(IDX_CTRL_MAIN, {11'h0, k[1], 1'b0, k[0], 1'b0, 1'b1});
			wr(IDX_COMMAND, 16'h1);
			rdc(IDX_COMMAND, 32'h1);
			wait_done;
			repeat (2) @(posedge core_clk);
			ex = exp_res(code, k[0], k[1], n);
			wm = wmatch(ex, lo, hi, 3'(k + 1));
			chk(32'(rdat[1:0]), {30'h0, wm, 1'b1});
			chk(32'(last_len), 32'(h * (k[0] ? 23 : 27)));
			chk(32'(fe_res_sel), 32'(k[0]));
			wr(IDX_FLAGS, 16'h0);
			rdc(IDX_FLAGS, {30'h0, wm, 1'b1});
			rdc(IDX_COMMAND, 32'h0);
			rdc(IDX_RESULT, 32'(ex));
			rdc(IDX_FLAGS, 32'h0);
		end
		wr(IDX_ACCUM, 16'h0);
		wr(IDX_CTRL_MAIN, 16'h0023);
		wr(IDX_COMMAND, 16'h1);
		chk(32'(fe_two_input_mode), 32'h1);
		r0 = rises;
		repeat (1200) @(posedge core_clk);
		chk(32'(rises - r0 > 2), 32'h1);
		rdc(IDX_COMMAND, 32'h1);
		@(negedge fe_convert);
		wr(IDX_CTRL_MAIN, 16'h0000);
		r0 = rises;
		repeat (300) @(posedge core_clk);
		chk(32'(rises - r0), 32'h0);
		rdc(IDX_COMMAND, 32'h0);
		wr(IDX_FLAGS, 16'h0003);
		rdc(IDX_FLAGS, 32'h0);
		standby_req <= 1'b1;
		wr(IDX_CTRL_MAIN, 16'h0001);
		wr(IDX_COMMAND, 16'h1);
		r0 = rises;
		repeat (300) @(posedge core_clk);
		chk(32'(rises - r0), 32'h0);
		wr(IDX_CTRL_MAIN, 16'h0081);
		wait_done;
		chk(32'(rises - r0 > 0), 32'h1);
		standby_req <= 1'b0;
		wr(IDX_FLAGS, 16'h0003);
		wr(IDX_COMMAND, 16'h1);
		r0 = rises;
		repeat (100) @(posedge core_clk);
		chk(32'(rises - r0), 32'h1);
		wait_done;
		wr(IDX_FLAGS, 16'h0003);
		deep_wake <= 1'b1;
		repeat (4) @(posedge core_clk);
		wr(IDX_COMMAND, 16'h1);
		r0 = rises;
		repeat (100) @(posedge core_clk);
		chk(32'(rises - r0), 32'h0);
		wait_done;
		deep_wake <= 1'b0;
		tally_and_finish;
	end
endmodule : adc_control_config_test
